// [hdl/timer16_pkg.sv]
// Purpose: Shared constants and types of the multimode 16-bit timer.
// Assumes: Byte-wide memory-mapped core accesses; 50 MHz system clock.
// Notes:   Offsets are byte addresses in the core's data space.
package timer16_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [7:0] ADDR_RELOAD_LOW  = 8'haa;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hab;
  localparam logic [7:0] ADDR_COUNT_LOW   = 8'hac;
  localparam logic [7:0] ADDR_COUNT_HIGH  = 8'had;
  localparam logic [7:0] ADDR_CONTROL     = 8'hae;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset and fixed count values
  localparam logic [15:0] COUNT_RESET   = 16'hffff;
  localparam logic [15:0] RELOAD_RESET  = 16'h0000;
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
  localparam logic [15:0] COUNT_ZERO     = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Control register field positions
  localparam int BIT_MODE_HI      = 7;
  localparam int BIT_MODE_MID     = 6;
  localparam int BIT_MODE_LO      = 5;
  localparam int BIT_RUN_FLAG     = 4;
  localparam int BIT_PENDING      = 3;
  localparam int BIT_ENABLE       = 2;
  localparam int BIT_CAPTURE_TYPE = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction clock derived from the system clock
  localparam int CLOCK_PERIOD_NS = 20;
  localparam int INSTR_PERIOD_NS = 1000;
  localparam int INSTR_DIV       = INSTR_PERIOD_NS / CLOCK_PERIOD_NS;
  localparam int DIV_WIDTH       = 6;
  localparam logic [DIV_WIDTH-1:0] DIV_LAST = DIV_WIDTH'(INSTR_DIV - 1);
  localparam logic [DIV_WIDTH-1:0] DIV_ZERO = 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Operating mode, coded as the two upper mode select bits
  typedef enum logic [1:0] {
    MODE_EVENT   = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_PWM     = 2'b10,
    MODE_DIFF    = 2'b11
  } mode_t;

  // Difference capture progress
  typedef enum logic {
    DIFF_WAIT_FIRST  = 1'b0,
    DIFF_WAIT_SECOND = 1'b1
  } diff_state_t;

endpackage

// [hdl/pin_edge_detect.sv]
// Purpose: Synchronise the timer pin and report its edges.
// Assumes: Pin is asynchronous to clock_in.
// Notes:   Edges come out two clocks after the pin moves.
`timescale 1ns/100ps
module pin_edge_detect (
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic reset_in,
  // Raw pin level
  input  wire logic pin_in,
  // Synchronised edges, one cycle each
  output logic      rise_out,
  output logic      fall_out
);

  logic sync_first;
  logic sync_second;
  logic level_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser; only the second stage is looked at
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      sync_first  <= 1'b0;
      sync_second <= 1'b0;
      level_prev  <= 1'b0;
    end else begin
      sync_first  <= pin_in;
      sync_second <= sync_first;
      level_prev  <= sync_second;
    end
  end

  // Edge detection on settled samples
  assign rise_out = sync_second & ~level_prev;
  assign fall_out = ~sync_second & level_prev;

endmodule

// [hdl/multimode_timer16.sv]
// Purpose: 16-bit down counter with reload/capture register and four modes.
// Assumes: Byte accesses from the core on clock_in; pin is asynchronous.
// Notes:   Instruction clock is a 1 in 50 enable of the 50 MHz clock.
// Notes on behaviour
// RQ1: Sixteen-bit counter, sixteen-bit reload/capture, eight-bit control, bytes high and low.
// RQ2: Reset gives counter all ones, reload zero, control zero.
// RQ3: Outside capture modes, control bit 4 starts or stops counting.
// RQ4: A running counter steps down by one on each count event.
// RQ5: Count event is instruction clock or pin edge, by mode.
// RQ6: Stepping down from zero underflows to all ones or reload value.
// RQ7: Control bit 2 enables the interrupt; source is underflow or capture.
// RQ8: Control bit 3 reads one while a timer interrupt is pending.
// RQ9: In capture modes control bit 4 is the underflow pending flag.
// RQ10: Bit 1 picks pulse or cycle capture; bit 0 is reserved.
// RQ11: Bits 7 to 5 with the capture type bit choose the mode.
// RQ12: Mode bits 00x count pin rising or falling edges, interrupt on underflow.
// RQ13: Mode bits 10x count instruction clocks, auto-reload, optionally toggle pin.
// RQ14: Mode bits 01x count instruction clocks, capture on one pin edge.
// RQ15: Mode bits 11x measure time between a selected pair of pin edges.
// RQ16: Timer pin shares the port pin; input or output by mode.
// RQ17: Interrupt reaches the core only with enable and global enable set.
// RQ18: Pulse-width underflow reloads, keeps counting and sets the pending flag.
// RQ19: Selected capture edge copies the counter into the capture register.
// RQ20: External events last one instruction clock and toggle at most half its rate.
// RQ21: Writing zero clears a pending flag; writing one leaves it alone.
`timescale 1ns/100ps
module multimode_timer16 (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       reset_in,
  // Core data-space access
  input  wire logic [7:0] addr_in,
  input  wire logic       write_en_in,
  input  wire logic       read_en_in,
  input  wire logic [7:0] write_data_in,
  output logic      [7:0] read_data_out,
  // Interrupt to the core
  input  wire logic       global_irq_enable_in,
  output logic            timer_irq_out,
  // Shared port pin
  input  wire logic       timer_pin_in,
  input  wire logic       port_level_in,
  output logic            timer_pin_out,
  output logic            timer_pin_oe_n_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  localparam int DIV_WIDTH_L = timer16_pkg::DIV_WIDTH;

  // Timer registers
  logic [15:0] count_reg;
  logic [15:0] reload_capture_reg;

  // Control fields
  logic [2:0]  mode_sel;
  logic        irq_mask_enable;
  logic        capture_type_sel;

  // Flags
  logic        run_or_underflow_flag;
  logic        irq_pending;

  // Pin level, prescaler and difference sequencing
  logic        toggle_level;
  logic [DIV_WIDTH_L-1:0] div_count;
  timer16_pkg::diff_state_t diff_state;

  // Next values
  logic [15:0] next_count;
  logic [15:0] next_reload;
  logic        next_run_flag;
  logic        next_pending;
  logic        next_toggle;
  logic [7:0]  next_read_data;
  timer16_pkg::diff_state_t next_diff_state;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode for the five byte registers
  wire hit_reload_low  = addr_in == timer16_pkg::ADDR_RELOAD_LOW;
  wire hit_reload_high = addr_in == timer16_pkg::ADDR_RELOAD_HIGH;
  wire hit_count_low   = addr_in == timer16_pkg::ADDR_COUNT_LOW;
  wire hit_count_high  = addr_in == timer16_pkg::ADDR_COUNT_HIGH;
  wire hit_control     = addr_in == timer16_pkg::ADDR_CONTROL;

  // Byte write strobes
  wire wr_reload_low  = write_en_in & hit_reload_low;   // see RQ1
  wire wr_reload_high = write_en_in & hit_reload_high;  // see RQ1
  wire wr_count_low   = write_en_in & hit_count_low;    // see RQ1
  wire wr_count_high  = write_en_in & hit_count_high;   // see RQ1
  wire wr_control     = write_en_in & hit_control;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode; the capture type bit only matters in difference capture
  wire timer16_pkg::mode_t mode = timer16_pkg::mode_t'(mode_sel[2:1]);  // see RQ11
  wire mode_event   = mode == timer16_pkg::MODE_EVENT;
  wire mode_pwm     = mode == timer16_pkg::MODE_PWM;
  wire mode_capture = mode == timer16_pkg::MODE_CAPTURE;
  wire mode_diff    = mode == timer16_pkg::MODE_DIFF;
  wire any_capture  = mode_capture | mode_diff;
  wire edge_is_fall = mode_sel[0];

  // Mode being written, so bit 4 can be read with its new meaning
  wire written_capture = write_data_in[timer16_pkg::BIT_MODE_MID];

  ////////////////////////////////////////////////////////////////////////////
  // Instruction clock enable: one pulse every INSTR_DIV system clocks
  wire instr_tick = div_count == timer16_pkg::DIV_LAST;

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      div_count <= timer16_pkg::DIV_ZERO;
    end else if (instr_tick) begin
      div_count <= timer16_pkg::DIV_ZERO;
    end else begin
      div_count <= div_count + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin edges; counting them relies on the source keeping each level
  // for a full instruction clock, which the sampler then never misses
  logic pin_rise;
  logic pin_fall;

  pin_edge_detect pin_edges (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .pin_in   (timer_pin_in),
    .rise_out (pin_rise),
    .fall_out (pin_fall)
  );  // see RQ20

  wire sel_edge = edge_is_fall ? pin_fall : pin_rise;  // see RQ12

  ////////////////////////////////////////////////////////////////////////////
  // Count event and underflow
  // Capture modes run as soon as they are selected; bit 4 is a flag there
  wire running    = any_capture | run_or_underflow_flag;  // see RQ3
  wire count_src  = mode_event ? sel_edge : instr_tick;   // see RQ5
  wire count_tick = running & count_src;                  // see RQ4
  wire at_zero    = count_reg == timer16_pkg::COUNT_ZERO;
  wire underflow  = count_tick & at_zero;                 // see RQ6

  // Reload modes take the reload value, capture modes wrap to all ones
  wire [15:0] underflow_value = any_capture ? timer16_pkg::COUNT_ALL_ONES
                                            : reload_capture_reg;  // see RQ6

  ////////////////////////////////////////////////////////////////////////////
  // Capture edges
  // Difference pair from bit 5 and the capture type bit:
  // 00 rise-fall, 01 rise-rise, 10 fall-rise, 11 fall-fall
  wire second_is_fall = ~(mode_sel[0] ^ capture_type_sel);       // see RQ15
  wire second_edge    = second_is_fall ? pin_fall : pin_rise;
  wire diff_start     = mode_diff & sel_edge &
                        (diff_state == timer16_pkg::DIFF_WAIT_FIRST);
  wire diff_capture   = mode_diff & second_edge &
                        (diff_state == timer16_pkg::DIFF_WAIT_SECOND);
  wire single_capture = mode_capture & sel_edge;                  // see RQ14
  wire capture_event  = single_capture | diff_capture;            // see RQ19

  ////////////////////////////////////////////////////////////////////////////
  // Flag sources: pending bit takes underflow in reload modes and
  // captures in capture modes; bit 4 takes underflow in capture modes
  wire pending_set   = any_capture ? capture_event : underflow;   // see RQ7
  wire underflow_set = any_capture & underflow;                   // see RQ9

  ////////////////////////////////////////////////////////////////////////////
  // Next count: core writes win, then restart, then underflow, then step
  // A write wins so software can always preload a known value
  always_comb begin
    next_count = count_reg;
    if (wr_count_low) begin
      next_count = {count_reg[15:8], write_data_in};            // see RQ1
    end else if (wr_count_high) begin
      next_count = {write_data_in, count_reg[7:0]};             // see RQ1
    end else if (diff_start) begin
      next_count = timer16_pkg::COUNT_ALL_ONES;                 // see RQ15
    end else if (underflow) begin
      next_count = underflow_value;                             // see RQ18
    end else if (count_tick) begin
      next_count = count_reg - 16'h0001;                        // see RQ4
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next reload/capture value; a byte write beats a capture
  always_comb begin
    next_reload = reload_capture_reg;
    if (wr_reload_low) begin
      next_reload = {reload_capture_reg[15:8], write_data_in};
    end else if (wr_reload_high) begin
      next_reload = {write_data_in, reload_capture_reg[7:0]};
    end else if (capture_event) begin
      next_reload = count_reg;                                  // see RQ19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending flag: hardware set beats a clearing write, so no event is lost
  always_comb begin
    next_pending = irq_pending;
    if (pending_set) begin
      next_pending = 1'b1;                                      // see RQ8
    end else if (wr_control & ~write_data_in[timer16_pkg::BIT_PENDING]) begin
      next_pending = 1'b0;                                      // see RQ21
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit 4: plain run control, or a set-wins underflow flag in capture modes
  always_comb begin
    next_run_flag = run_or_underflow_flag;
    if (underflow_set) begin
      next_run_flag = 1'b1;                                     // see RQ9
    end else if (wr_control) begin
      if (written_capture) begin
        if (~write_data_in[timer16_pkg::BIT_RUN_FLAG]) begin
          next_run_flag = 1'b0;                                 // see RQ21
        end
      end else begin
        next_run_flag = write_data_in[timer16_pkg::BIT_RUN_FLAG];  // see RQ3
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Difference capture sequencing; a control write rearms it
  always_comb begin
    next_diff_state = diff_state;
    if (wr_control) begin
      next_diff_state = timer16_pkg::DIFF_WAIT_FIRST;
    end else if (diff_start) begin
      next_diff_state = timer16_pkg::DIFF_WAIT_SECOND;          // see RQ15
    end else if (diff_capture) begin
      next_diff_state = timer16_pkg::DIFF_WAIT_FIRST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Toggle output: starts from the port's own level when toggling is
  // selected, so the pin does not glitch when the timer takes it over
  wire enter_toggle = wr_control & (write_data_in[7:5] == 3'b101);
  wire toggle_now   = mode_pwm & mode_sel[0] & underflow;

  always_comb begin
    next_toggle = toggle_level;
    if (enter_toggle) begin
      next_toggle = port_level_in;                              // see RQ16
    end else if (toggle_now) begin
      next_toggle = ~toggle_level;                              // see RQ13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses and the reserved bit read zero
  wire [7:0] control_view = {mode_sel,
                             run_or_underflow_flag,
                             irq_pending,
                             irq_mask_enable,
                             capture_type_sel,
                             1'b0};                             // see RQ10

  always_comb begin
    next_read_data = 8'h00;
    if (hit_reload_low) begin
      next_read_data = reload_capture_reg[7:0];
    end else if (hit_reload_high) begin
      next_read_data = reload_capture_reg[15:8];
    end else if (hit_count_low) begin
      next_read_data = count_reg[7:0];
    end else if (hit_count_high) begin
      next_read_data = count_reg[15:8];
    end else if (hit_control) begin
      next_read_data = control_view;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data registers
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      count_reg          <= timer16_pkg::COUNT_RESET;           // see RQ2
      reload_capture_reg <= timer16_pkg::RELOAD_RESET;          // see RQ2
    end else begin
      count_reg          <= next_count;
      reload_capture_reg <= next_reload;
    end
  end

  // Control fields written straight from the core
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      mode_sel         <= timer16_pkg::CONTROL_RESET[7:5];      // see RQ2
      irq_mask_enable  <= timer16_pkg::CONTROL_RESET[2];
      capture_type_sel <= timer16_pkg::CONTROL_RESET[1];
    end else if (wr_control) begin
      mode_sel         <= write_data_in[7:5];                   // see RQ11
      irq_mask_enable  <= write_data_in[timer16_pkg::BIT_ENABLE];        // see RQ7
      capture_type_sel <= write_data_in[timer16_pkg::BIT_CAPTURE_TYPE];  // see RQ10
    end
  end

  // Flags, sequencing and pin level
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      run_or_underflow_flag <= timer16_pkg::CONTROL_RESET[4];
      irq_pending           <= timer16_pkg::CONTROL_RESET[3];
      diff_state            <= timer16_pkg::DIFF_WAIT_FIRST;
      toggle_level          <= 1'b0;
    end else begin
      run_or_underflow_flag <= next_run_flag;
      irq_pending           <= next_pending;
      diff_state            <= next_diff_state;
      toggle_level          <= next_toggle;
    end
  end

  // Read data is held until the next read
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      read_data_out <= 8'h00;
    end else if (read_en_in) begin
      read_data_out <= next_read_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt: any pending source, gated by the local and global enables
  wire irq_source = irq_pending | (any_capture & run_or_underflow_flag);  // see RQ7
  assign timer_irq_out = irq_source & irq_mask_enable &
                         global_irq_enable_in;                  // see RQ17

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive: only the toggling pulse-width mode takes the pin;
  // every other mode leaves it as an input for the port or the timer
  assign timer_pin_out      = toggle_level;
  assign timer_pin_oe_n_out = ~(mode_pwm & mode_sel[0]);        // see RQ16

endmodule

// [tb/timer16_checker_assertions.sv]
// Purpose: Port-level checks of the multimode timer.
// Assumes: Every software write passes over the byte bus.
// Notes:   Only written fields are shadowed; hardware flags are not.
`timescale 1ns/100ps
module timer16_checker (
  // Clock and reset
  input wire logic       clock_in,
  input wire logic       reset_in,
  // Core access
  input wire logic [7:0] addr_in,
  input wire logic       write_en_in,
  input wire logic       read_en_in,
  input wire logic [7:0] write_data_in,
  input wire logic [7:0] read_data_out,
  // Interrupt and pin
  input wire logic       global_irq_enable_in,
  input wire logic       timer_irq_out,
  input wire logic       timer_pin_out,
  input wire logic       timer_pin_oe_n_out
);
  logic [7:0] ctrl_sh;
  logic [7:0] rel_sh;
  logic       cap_seen;
  // Decoded accesses
  wire wr_ctrl   = write_en_in && addr_in == timer16_pkg::ADDR_CONTROL;
  wire wr_rel    = write_en_in && addr_in == timer16_pkg::ADDR_RELOAD_LOW;
  wire toggle_md = ctrl_sh[7:5] == 3'b101;
  wire unmapped  = addr_in < timer16_pkg::ADDR_RELOAD_LOW || addr_in > timer16_pkg::ADDR_CONTROL;

  // Shadows; once a capture mode ran the reload can no longer be predicted
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl_sh  <= 8'h00;
      rel_sh   <= 8'h00;
      cap_seen <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_sh <= write_data_in;
      end
      if (wr_rel) begin
        rel_sh <= write_data_in;
      end
      cap_seen <= cap_seen | ctrl_sh[6];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  sequence ctrl_read_s;
    read_en_in && addr_in == timer16_pkg::ADDR_CONTROL;
  endsequence
  sequence rel_read_s;
    read_en_in && addr_in == timer16_pkg::ADDR_RELOAD_LOW && !cap_seen && !ctrl_sh[6];
  endsequence

  irq_global_gate_a: assert property (timer_irq_out |-> global_irq_enable_in)
    else $error("interrupt without global enable");
  irq_enable_gate_a: assert property (timer_irq_out |-> ctrl_sh[2])
    else $error("interrupt while masked");
  pin_drive_mode_a: assert property (timer_pin_oe_n_out == !toggle_md)
    else $error("pin drive does not follow mode");
  pin_hold_a: assert property (!toggle_md && !$past(wr_ctrl) |-> $stable(timer_pin_out))
    else $error("pin moved outside toggle mode");
  unmapped_read_a: assert property (read_en_in && unmapped |=> read_data_out == 8'h00)
    else $error("unmapped read not zero");
  reserved_bit_a: assert property (ctrl_read_s |=> read_data_out[0] == 1'b0)
    else $error("reserved control bit set");
  mode_readback_a: assert property (ctrl_read_s |=> read_data_out[7:5] == $past(ctrl_sh[7:5])
    && read_data_out[2:1] == $past(ctrl_sh[2:1]))
    else $error("control fields read back wrong");
  reload_readback_a: assert property (rel_read_s |=> read_data_out == $past(rel_sh))
    else $error("reload low byte read back wrong");
  read_hold_a: assert property (!read_en_in |=> $stable(read_data_out))
    else $error("read data moved without a read");
endmodule

bind multimode_timer16 timer16_checker timer16_checker_i (.*);

// [tb/pin_source_model.sv]
// Purpose: External event source on the shared timer pin.
// Assumes: The bench asks for levels; the model paces them.
// Notes:   A request is delayed until the last level stood 50 clocks.
`timescale 1ns/100ps
module pin_source_model (
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic reset_in,
  // Requested level and the timer's own drive
  input  wire logic level_req_in,
  input  wire logic drive_val_in,
  input  wire logic drive_oe_n_in,
  // Resolved pin
  output logic      pin_level_out
);
  logic       src_level;
  logic [5:0] hold_cnt;
  // Each level stands one instruction clock at least, so edges stay legal
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      src_level <= 1'b0;
      hold_cnt  <= 6'h00;
    end else if (level_req_in != src_level && hold_cnt >= 6'h32) begin
      src_level <= level_req_in;
      hold_cnt  <= 6'h00;
    end else if (hold_cnt != 6'h3f) begin
      hold_cnt <= hold_cnt + 6'h01;
    end
  end
  // Timer drive wins only while it enables its output
  assign pin_level_out = drive_oe_n_in ? src_level : drive_val_in;
endmodule

// [tb/multimode_timer16_tb_top.sv]
// Purpose: Self-checking bench of the multimode timer.
// Assumes: Inputs change at the falling clock edge.
// Notes:   Pin edges come from the pacing source model.
`timescale 1ns/100ps
module multimode_timer16_tb_top;
  logic       clock_in;
  logic       reset_in;
  logic [7:0] addr_in;
  logic       write_en_in;
  logic       read_en_in;
  logic [7:0] write_data_in;
  logic [7:0] read_data_out;
  logic       global_irq_enable_in;
  logic       timer_irq_out;
  logic       timer_pin_in;
  logic       port_level_in;
  logic       timer_pin_out;
  logic       timer_pin_oe_n_out;
  logic       level_req;
  logic [7:0] rd_lo;
  logic [7:0] rd_hi;
  logic [7:0] rel;
  int         error_cnt = 0;
  int         num_checks = 0;
  int         cycles = 0;
  int         k;
  int         gap;
  // Byte addresses used by the scenarios
  localparam logic [7:0] RELOAD_LO = timer16_pkg::ADDR_RELOAD_LOW;
  localparam logic [7:0] COUNT_LO  = timer16_pkg::ADDR_COUNT_LOW;
  localparam logic [7:0] CONTROL   = timer16_pkg::ADDR_CONTROL;

  multimode_timer16 multimode_timer16_i (.*);
  pin_source_model pin_source_model_i (.clock_in(clock_in), .reset_in(reset_in),
    .level_req_in(level_req), .drive_val_in(timer_pin_out),
    .drive_oe_n_in(timer_pin_oe_n_out), .pin_level_out(timer_pin_in));

  //////////////////////////////////////////////////////////////////////////////
  // Compare within a tolerance, zero for exact values
  task automatic check(string what, logic [15:0] exp, logic [15:0] got, int tol = 0);
    int d;
    d = int'(got) - int'(exp);
    num_checks++;
    if ($isunknown(got) || d > tol || d < -tol) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // Byte bus cycles, one strobe cycle each
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clock_in);
    addr_in = a;
    write_data_in = d;
    write_en_in = 1'b1;
    @(negedge clock_in);
    write_en_in = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [7:0] d);
    @(negedge clock_in);
    addr_in = a;
    read_en_in = 1'b1;
    @(negedge clock_in);
    read_en_in = 1'b0;
    d = read_data_out;
  endtask
  task automatic pin_set(logic lvl, int hold);
    @(negedge clock_in);
    level_req = lvl;
    repeat (hold) @(negedge clock_in);
  endtask
  task automatic wait_toggle(output int n);
    logic p;
    p = timer_pin_out;
    n = 0;
    while (timer_pin_out === p && n < 2000) begin
      @(negedge clock_in);
      n++;
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // Main sequence
  initial begin
    reset_in = 1'b1;
    addr_in = 8'h00;
    write_en_in = 1'b0;
    read_en_in = 1'b0;
    write_data_in = 8'h00;
    global_irq_enable_in = 1'b0;
    port_level_in = 1'b0;
    level_req = 1'b0;
    void'($urandom(32'h75d15352));
    repeat (8) @(posedge clock_in);
    @(negedge clock_in);
    reset_in = 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(RELOAD_LO + 8'(i), rd_lo);
      check("reset value", (i == 2 || i == 3) ? 16'hff : 16'h0, 16'(rd_lo));
    end
    rd(8'haf, rd_lo);
    check("unmapped read", 16'h0, 16'(rd_lo));
    // Toggled pulse width of reload plus one ticks; high count byte is cleared
    // or the first underflow lies far beyond the hang guard
    rel = 8'h03 + 8'($urandom % 4);
    wr(COUNT_LO, 8'h02);
    wr(timer16_pkg::ADDR_COUNT_HIGH, 8'h00);
    wr(RELOAD_LO, rel);
    port_level_in = 1'b1;
    global_irq_enable_in = 1'b1;
    wr(CONTROL, 8'hb4);
    check("pin start", 16'h1, 16'(timer_pin_out));
    check("pin drive", 16'h0, 16'(timer_pin_oe_n_out));
    wait_toggle(k);
    wait_toggle(k);
    check("reload period", 16'((rel + 1) * 50), 16'(k));
    rd(CONTROL, rd_lo);
    check("pending set", 16'h1, 16'(rd_lo[3]));
    check("irq raised", 16'h1, 16'(timer_irq_out));
    global_irq_enable_in = 1'b0;
    @(negedge clock_in);
    check("irq masked", 16'h0, 16'(timer_irq_out));
    global_irq_enable_in = 1'b1;
    wr(CONTROL, 8'hbc);
    rd(CONTROL, rd_lo);
    check("pending kept", 16'h1, 16'(rd_lo[3]));
    wr(CONTROL, 8'hb4);
    rd(CONTROL, rd_lo);
    check("pending cleared", 16'h0, 16'(rd_lo[3]));
    wr(CONTROL, 8'ha0);
    wr(COUNT_LO, 8'h5a);
    repeat (200) @(negedge clock_in);
    rd(COUNT_LO, rd_lo);
    check("stopped count", 16'h5a, 16'(rd_lo));
    // Event counting on both edges; one extra rise tells the polarity apart
    for (int fe = 0; fe < 2; fe++) begin
      wr(CONTROL, 8'h00);
      pin_set(1'b0, 60);
      k = 2 + $urandom % 4;
      rel = 8'h10 + 8'($urandom % 8'he0);
      wr(RELOAD_LO, rel);
      wr(COUNT_LO, 8'(k - 1));
      wr(CONTROL, 8'h14 | 8'(fe << 5));
      repeat (k) begin
        pin_set(1'b1, 60);
        pin_set(1'b0, 60);
      end
      pin_set(1'b1, 60);
      rd(COUNT_LO, rd_lo);
      check("event count", {8'h00, rel - 8'(1 - fe)}, 16'(rd_lo));
      rd(CONTROL, rd_lo);
      check("underflow flag", 16'h1, 16'(rd_lo[3]));
    end
    // Single-edge capture on a rise
    pin_set(1'b0, 60);
    wr(CONTROL, 8'h40);
    pin_set(1'b1, 60);
    rd(RELOAD_LO, rd_lo);
    rd(timer16_pkg::ADDR_RELOAD_HIGH, rd_hi);
    rel = rd_lo;
    rd(COUNT_LO, rd_lo);
    check("capture value", {rd_hi, rd_lo} + 16'h0001, {rd_hi, rel}, 1);
    rd(CONTROL, rd_lo);
    check("capture flag", 16'h1, 16'(rd_lo[3]));
    // Difference capture over all four edge pairs
    for (int c = 0; c < 4; c++) begin
      pin_set(c[1], 60);
      wr(CONTROL, 8'hc0 | 8'(c[1] << 5) | 8'(c[0] << 1));
      gap = 100 + $urandom % 300;
      pin_set(~c[1], gap);
      if (c[0]) begin
        pin_set(c[1], 60);
      end
      pin_set(c[1] ^ c[0], 60);
      rd(RELOAD_LO, rd_lo);
      rd(timer16_pkg::ADDR_RELOAD_HIGH, rd_hi);
      check("difference", 16'((gap + 1 + 61 * c[0]) / 50), 16'hffff - {rd_hi, rd_lo}, 1);
    end
    end_of_test();
  end
endmodule
